// ---- hdl/cocr_regs.v ----
// Purpose: Configuration register bank for one clock output channel and decode of its fields.
// Assumes: Host port is a plain synchronous byte port; page switching is done through 0xFF.
// Notes:   Reads answer one clock after the read strobe; unmapped offsets read as zero.
//
// Functional notes
// - Divide ratio bits 23:16, 15:8, 7:0 live at 0x60, 0x61, 0x62.
// - Divide ratio bits 29:28 sit in bits 7:6 of the standard register.
// - Delay bits 5:0 give coarse skew of 0 to 63 oscillator periods.
// - Delay bits 7:6 give fine skew of 0 to 3 steps of 30 ps.
// - Bit 4 of 0x57 extends fine skew to three bits, 0 to 4 steps.
// - Bits 3:0 of 0x57 select termination and single-ended pin usage.
// - Bits 7:6 of 0x63 route clock legs onto the pins in single-ended mode.
// - Three-bit standard field selects LVDS, LVPECL, CML, HCSL or boosted LVDS.
// - Bits 4:3 of 0x65 select output supply of 1.8, 2.5 or 3.3 V.
// - Page selector at 0xFF, on every page, chooses which page lower offsets reach.
`include "cocr_map.vh"

module cocr_regs (
	input  wire        i_clk,
	input  wire        i_rst_n,
	input  wire [7:0]  i_addr,
	input  wire [7:0]  i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [7:0]  o_rdata,
	output reg  [7:0]  o_page,
	output reg  [29:0] o_output_divide_ratio,
	output reg  [5:0]  o_coarse_skew,
	output reg  [2:0]  o_fine_skew_steps,
	output reg         o_fine_skew_reserved,
	output reg         o_term_external_diff,
	output reg         o_term_pullup_diff,
	output reg         o_term_pulldown_diff,
	output reg         o_positive_output_pin_en,
	output reg         o_negative_output_pin_en,
	output reg         o_term_reserved,
	output reg         o_positive_pin_complement,
	output reg         o_negative_pin_complement,
	output reg  [2:0]  o_se_drive_strength,
	output reg  [5:0]  o_output_standard_select,
	output reg         o_standard_reserved,
	output reg  [2:0]  o_output_supply_setting,
	output reg         o_supply_reserved
);

	reg [7:0] page_reg;
	reg [7:0] std_select_reg;
	reg [7:0] term_mode_reg;
	reg [7:0] div_high_reg;
	reg [7:0] div_mid_reg;
	reg [7:0] div_low_reg;
	reg [7:0] se_drive_reg;
	reg [7:0] skew_delay_reg;
	reg [7:0] supply_reg;
	reg [7:0] rdata_next;

	wire       page_hit;
	wire [3:0] term_code;
	wire [1:0] phase_code;
	wire [2:0] fine_code;
	wire [2:0] std_code;
	wire [1:0] supply_code;
	wire       single_ended;

	assign page_hit     = (page_reg == `COCR_PAGE_THIS);
	assign term_code    = term_mode_reg[`COCR_TERM_MSB:`COCR_TERM_LSB];
	assign phase_code   = se_drive_reg[`COCR_PHASE_MSB:`COCR_PHASE_LSB];
	assign fine_code    = {term_mode_reg[`COCR_FINE_EXT_BIT], skew_delay_reg[`COCR_FINE_MSB:`COCR_FINE_LSB]};
	assign std_code     = std_select_reg[`COCR_STD_MSB:`COCR_STD_LSB];
	assign supply_code  = supply_reg[`COCR_SUPPLY_MSB:`COCR_SUPPLY_LSB];
	assign single_ended = (term_code == `COCR_TERM_SE_POS) || (term_code == `COCR_TERM_SE_NEG) ||
	                      (term_code == `COCR_TERM_SE_BOTH);

	////////////////////////////////////////////////////////////////////////////////
	// Register writes.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			page_reg       <= `COCR_RESET_BYTE;
			std_select_reg <= `COCR_RESET_BYTE;
			term_mode_reg  <= `COCR_RESET_BYTE;
			div_high_reg   <= `COCR_RESET_BYTE;
			div_mid_reg    <= `COCR_RESET_BYTE;
			div_low_reg    <= `COCR_RESET_BYTE;
			se_drive_reg   <= `COCR_RESET_BYTE;
			skew_delay_reg <= `COCR_RESET_BYTE;
			supply_reg     <= `COCR_RESET_BYTE;
		end else if (i_wr) begin
			if (i_addr == `COCR_OFS_PAGE_SELECT) begin
				page_reg <= i_wdata;
			end else if (page_hit && (i_addr == `COCR_OFS_STD_SELECT)) begin
				std_select_reg <= i_wdata;
			end else if (page_hit && (i_addr == `COCR_OFS_TERM_MODE)) begin
				term_mode_reg <= i_wdata;
			end else if (page_hit && (i_addr == `COCR_OFS_DIV_HIGH)) begin
				div_high_reg <= i_wdata;
			end else if (page_hit && (i_addr == `COCR_OFS_DIV_MID)) begin
				div_mid_reg <= i_wdata;
			end else if (page_hit && (i_addr == `COCR_OFS_DIV_LOW)) begin
				div_low_reg <= i_wdata;
			end else if (page_hit && (i_addr == `COCR_OFS_SE_DRIVE)) begin
				se_drive_reg <= i_wdata;
			end else if (page_hit && (i_addr == `COCR_OFS_SKEW_DELAY)) begin
				skew_delay_reg <= i_wdata;
			end else if (page_hit && (i_addr == `COCR_OFS_SUPPLY)) begin
				supply_reg <= i_wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read multiplexer.
	always @* begin
		rdata_next = `COCR_RESET_BYTE;
		if (i_addr == `COCR_OFS_PAGE_SELECT) begin
			rdata_next = page_reg;
		end else if (page_hit && (i_addr == `COCR_OFS_STD_SELECT)) begin
			rdata_next = std_select_reg;
		end else if (page_hit && (i_addr == `COCR_OFS_TERM_MODE)) begin
			rdata_next = term_mode_reg;
		end else if (page_hit && (i_addr == `COCR_OFS_DIV_HIGH)) begin
			rdata_next = div_high_reg;
		end else if (page_hit && (i_addr == `COCR_OFS_DIV_MID)) begin
			rdata_next = div_mid_reg;
		end else if (page_hit && (i_addr == `COCR_OFS_DIV_LOW)) begin
			rdata_next = div_low_reg;
		end else if (page_hit && (i_addr == `COCR_OFS_SE_DRIVE)) begin
			rdata_next = se_drive_reg;
		end else if (page_hit && (i_addr == `COCR_OFS_SKEW_DELAY)) begin
			rdata_next = skew_delay_reg;
		end else if (page_hit && (i_addr == `COCR_OFS_SUPPLY)) begin
			rdata_next = supply_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data register, loaded only on a read strobe.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Page selector mirror.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_page <= 8'h00;
		end else begin
			o_page <= page_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Divide ratio assembled from its byte registers.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_output_divide_ratio <= 30'h0000_0000;
		end else begin
			o_output_divide_ratio <= {std_select_reg[`COCR_DIV_TOP_MSB:`COCR_DIV_TOP_LSB],
			                          4'h0, div_high_reg, div_mid_reg, div_low_reg};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Coarse skew count.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_coarse_skew <= 6'h00;
		end else begin
			o_coarse_skew <= skew_delay_reg[`COCR_COARSE_MSB:`COCR_COARSE_LSB];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fine skew steps; reserved codes give no added delay.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_fine_skew_steps <= 3'h0;
		end else begin
			if (fine_code > `COCR_FINE_MAX_STEPS) begin
				o_fine_skew_steps <= 3'h0;
			end else begin
				o_fine_skew_steps <= fine_code;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fine skew reserved flag.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_fine_skew_reserved <= 1'b0;
		end else begin
			o_fine_skew_reserved <= (fine_code > `COCR_FINE_MAX_STEPS);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Differential termination flags.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_term_external_diff <= 1'b1;
			o_term_pullup_diff   <= 1'b0;
			o_term_pulldown_diff <= 1'b0;
		end else begin
			o_term_external_diff <= (term_code == `COCR_TERM_EXT_DIFF);
			o_term_pullup_diff   <= (term_code == `COCR_TERM_PULLUP);
			o_term_pulldown_diff <= (term_code == `COCR_TERM_PULLDN);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Single-ended pin enables.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_positive_output_pin_en <= 1'b0;
			o_negative_output_pin_en <= 1'b0;
		end else begin
			o_positive_output_pin_en <= (term_code == `COCR_TERM_SE_POS) || (term_code == `COCR_TERM_SE_BOTH);
			o_negative_output_pin_en <= (term_code == `COCR_TERM_SE_NEG) || (term_code == `COCR_TERM_SE_BOTH);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Termination reserved flag.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_term_reserved <= 1'b0;
		end else begin
			o_term_reserved <= !single_ended && (term_code != `COCR_TERM_EXT_DIFF) &&
			                   (term_code != `COCR_TERM_PULLUP) && (term_code != `COCR_TERM_PULLDN);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Clock leg routing; differential modes keep true and complement.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_positive_pin_complement <= 1'b0;
			o_negative_pin_complement <= 1'b1;
		end else begin
			if (single_ended) begin
				o_positive_pin_complement <= phase_code[1];
				o_negative_pin_complement <= ~phase_code[0];
			end else begin
				o_positive_pin_complement <= 1'b0;
				o_negative_pin_complement <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Single-ended drive strength, passed on as stored.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_se_drive_strength <= 3'h0;
		end else begin
			o_se_drive_strength <= se_drive_reg[`COCR_DRIVE_MSB:`COCR_DRIVE_LSB];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Driver standard decode, one-hot with a reserved flag.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_output_standard_select <= 6'h01;
			o_standard_reserved      <= 1'b0;
		end else begin
			o_output_standard_select <= 6'h00;
			o_standard_reserved      <= 1'b0;
			case (std_code)
				`COCR_STD_LVDS:        o_output_standard_select <= 6'h01;
				`COCR_STD_LVPECL_CM:   o_output_standard_select <= 6'h02;
				`COCR_STD_CML:         o_output_standard_select <= 6'h04;
				`COCR_STD_HCSL:        o_output_standard_select <= 6'h08;
				`COCR_STD_LVDS_BOOST:  o_output_standard_select <= 6'h10;
				`COCR_STD_LVPECL_NOCM: o_output_standard_select <= 6'h20;
				default:               o_standard_reserved <= 1'b1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Supply level decode, one-hot with a reserved flag.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_output_supply_setting <= 3'h1;
			o_supply_reserved       <= 1'b0;
		end else begin
			o_output_supply_setting <= 3'h0;
			o_supply_reserved       <= 1'b0;
			case (supply_code)
				`COCR_SUPPLY_1V8: o_output_supply_setting <= 3'h1;
				`COCR_SUPPLY_2V5: o_output_supply_setting <= 3'h2;
				`COCR_SUPPLY_3V3: o_output_supply_setting <= 3'h4;
				default:          o_supply_reserved <= 1'b1;
			endcase
		end
	end

endmodule // cocr_regs

// ---- hdl/cocr_map.vh ----
// Purpose: Offsets, field positions and reset values of the clock output configuration bank.
// Assumes: Byte-wide registers on an 8-bit offset space.
// Notes:   Included by cocr_regs.v only.
`ifndef COCR_MAP_VH
`define COCR_MAP_VH

`define COCR_OFS_STD_SELECT   8'h56
`define COCR_OFS_TERM_MODE    8'h57
`define COCR_OFS_DIV_HIGH     8'h60
`define COCR_OFS_DIV_MID      8'h61
`define COCR_OFS_DIV_LOW      8'h62
`define COCR_OFS_SE_DRIVE     8'h63
`define COCR_OFS_SKEW_DELAY   8'h64
`define COCR_OFS_SUPPLY       8'h65
`define COCR_OFS_PAGE_SELECT  8'hFF

`define COCR_PAGE_THIS        8'h02
`define COCR_RESET_BYTE       8'h00

`define COCR_STD_LSB          0
`define COCR_STD_MSB          2
`define COCR_DIV_TOP_LSB      6
`define COCR_DIV_TOP_MSB      7
`define COCR_TERM_LSB         0
`define COCR_TERM_MSB         3
`define COCR_FINE_EXT_BIT     4
`define COCR_PHASE_LSB        6
`define COCR_PHASE_MSB        7
`define COCR_DRIVE_LSB        0
`define COCR_DRIVE_MSB        2
`define COCR_COARSE_LSB       0
`define COCR_COARSE_MSB       5
`define COCR_FINE_LSB         6
`define COCR_FINE_MSB         7
`define COCR_SUPPLY_LSB       3
`define COCR_SUPPLY_MSB       4

`define COCR_TERM_EXT_DIFF    4'h0
`define COCR_TERM_PULLUP      4'h2
`define COCR_TERM_PULLDN      4'h1
`define COCR_TERM_SE_POS      4'h4
`define COCR_TERM_SE_NEG      4'h8
`define COCR_TERM_SE_BOTH     4'hC

`define COCR_STD_LVDS         3'h0
`define COCR_STD_LVPECL_CM    3'h1
`define COCR_STD_CML          3'h2
`define COCR_STD_HCSL         3'h3
`define COCR_STD_LVDS_BOOST   3'h4
`define COCR_STD_LVPECL_NOCM  3'h5

`define COCR_SUPPLY_1V8       2'h0
`define COCR_SUPPLY_2V5       2'h1
`define COCR_SUPPLY_3V3       2'h2

`define COCR_FINE_MAX_STEPS   3'h4
`define COCR_FINE_STEP_PS     30

`endif

// ---- tb/cocr_regs_assertions.sv ----
// Purpose: Port assertions for the clock output configuration bank.
// Assumes: The bank answers on page 0x02.
// Notes:   Attached by bind.
module cocr_regs_checker (
	input logic        i_clk,
	input logic        i_rst_n,
	input logic [7:0]  i_addr,
	input logic [7:0]  i_wdata,
	input logic        i_wr,
	input logic        i_rd,
	input logic [7:0]  o_rdata,
	input logic [7:0]  o_page,
	input logic [29:0] o_output_divide_ratio,
	input logic [5:0]  o_coarse_skew,
	input logic [2:0]  o_se_drive_strength,
	input logic        o_term_external_diff,
	input logic        o_positive_pin_complement,
	input logic        o_negative_pin_complement,
	input logic        o_standard_reserved,
	input logic        o_supply_reserved
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// A write on this page followed by an idle cycle.
	sequence s_wr(a);
		i_wr && i_addr == a && o_page == 8'h02 ##1 !i_wr;
	endsequence
	property p_div_low; s_wr(8'h62) |-> ##1 o_output_divide_ratio[7:0] == $past(i_wdata, 2); endproperty
	property p_div_high; s_wr(8'h60) |-> ##1 o_output_divide_ratio[23:16] == $past(i_wdata, 2); endproperty
	property p_div_top; s_wr(8'h56) |-> ##1 o_output_divide_ratio[29:24] == {$past(i_wdata[7:6], 2), 4'h0}; endproperty
	property p_coarse; s_wr(8'h64) |-> ##1 o_coarse_skew == $past(i_wdata[5:0], 2); endproperty
	property p_drive; s_wr(8'h63) |-> ##1 o_se_drive_strength == $past(i_wdata[2:0], 2); endproperty
	property p_std; s_wr(8'h56) |-> ##1 o_standard_reserved == ($past(i_wdata[2:0], 2) > 3'h5); endproperty
	property p_supply; s_wr(8'h65) |-> ##1 o_supply_reserved == ($past(i_wdata[4:3], 2) == 2'h3); endproperty
	property p_legs; o_term_external_diff |-> !o_positive_pin_complement && o_negative_pin_complement; endproperty
	property p_page_rd; i_rd && !i_wr && i_addr == 8'hFF |=> o_rdata == o_page; endproperty
	property p_rd_hold; !i_rd |=> $stable(o_rdata); endproperty
	a_div_low: assert property (p_div_low) else $error("low ratio byte wrong");
	a_div_high: assert property (p_div_high) else $error("high ratio byte wrong");
	a_div_top: assert property (p_div_top) else $error("top ratio bits wrong");
	a_coarse: assert property (p_coarse) else $error("coarse skew wrong");
	a_drive: assert property (p_drive) else $error("drive strength wrong");
	a_std: assert property (p_std) else $error("standard flag wrong");
	a_supply: assert property (p_supply) else $error("supply flag wrong");
	a_legs: assert property (p_legs) else $error("differential legs wrong");
	a_page_rd: assert property (p_page_rd) else $error("page read wrong");
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule // cocr_regs_checker
bind cocr_regs cocr_regs_checker u_chk (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_page,
	.o_output_divide_ratio, .o_coarse_skew, .o_se_drive_strength, .o_term_external_diff,
	.o_positive_pin_complement, .o_negative_pin_complement, .o_standard_reserved, .o_supply_reserved);

// ---- tb/cocr_regs_tb_top.sv ----
// Purpose: Self-checking bench for the clock output configuration bank.
// Assumes: Decoded outputs settle one edge after the write edge.
// Notes:   Table rows are all written, then all read back.
module cocr_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_clk, i_rst_n, i_wr, i_rd;
	logic [7:0]  i_addr, i_wdata;
	wire  [7:0]  rdat, page;
	wire  [29:0] ratio;
	wire  [5:0]  coarse, std;
	wire  [2:0]  fine, drive, sup;
	wire         fres, ext, pen, nen, pc, nc, sres, ures, tpu, tpd, tres;
	int          error_cnt, cmp_count, i, cyc;
	logic [23:0] rows [10] = '{24'hFF_0202, 24'h57_1414, 24'h60_ABAB, 24'h61_CDCD, 24'h62_EFEF,
		24'h63_8787, 24'h64_3F3F, 24'h65_1010, 24'h56_C3C3, 24'h70_5A00};
	logic [1:0]  leg_exp [4] = '{2'h1, 2'h0, 2'h3, 2'h2};
	cocr_regs dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(rdat), .o_page(page), .o_output_divide_ratio(ratio), .o_coarse_skew(coarse),
		.o_fine_skew_steps(fine), .o_fine_skew_reserved(fres), .o_term_external_diff(ext),
		.o_term_pullup_diff(tpu), .o_term_pulldown_diff(tpd), .o_positive_output_pin_en(pen),
		.o_negative_output_pin_en(nen), .o_term_reserved(tres), .o_positive_pin_complement(pc),
		.o_negative_pin_complement(nc), .o_se_drive_strength(drive), .o_output_standard_select(std),
		.o_standard_reserved(sres), .o_output_supply_setting(sup), .o_supply_reserved(ures));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk(rdat, e);
	endtask
	task automatic rst_chk;
		chk({rdat, page}, 16'h0000);
		chk(ratio, 30'h0000_0000);
		chk({ext, nc, pc, std, sup}, {1'h1, 1'h1, 1'h0, 6'h01, 3'h1});
	endtask
	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			error_cnt++;
			conclude();
		end
	end
	initial begin
		{i_rst_n, i_wr, i_rd, i_addr, i_wdata} = 19'h0;
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		#1;
		rst_chk();
		wr(8'h64, 8'h3F);
		rd(8'h64, 8'h00);
		for (i = 0; i < 10; i++) wr(rows[i][23:16], rows[i][15:8]);
		for (i = 0; i < 10; i++) rd(rows[i][23:16], rows[i][7:0]);
		chk(ratio, 30'h30AB_CDEF);
		chk({coarse, fine, fres}, {6'h3F, 3'h4, 1'h0});
		chk({pen, nen, pc, nc, drive}, {4'hB, 3'h7});
		chk({std, sres, sup, ures}, {6'h08, 1'h0, 3'h4, 1'h0});
		wr(8'h64, 8'h80);
		chk({fine, fres}, {3'h0, 1'h1});
		wr(8'h57, 8'h00);
		chk({fine, fres, ext, pc, nc}, {3'h2, 1'h0, 1'h1, 1'h0, 1'h1});
		wr(8'h57, 8'h0C);
		for (i = 0; i < 4; i++) begin
			wr(8'h63, {i[1:0], 6'h07});
			chk({pen, nen, pc, nc}, {2'h3, leg_exp[i]});
		end
		wr(8'h57, 8'h08);
		chk({pen, nen, pc, nc}, 4'h6);
		wr(8'h57, 8'h02);
		chk({ext, tpu, tpd, tres, pc, nc}, 6'h11);
		wr(8'h57, 8'h01);
		chk({ext, tpu, tpd, tres, pc, nc}, 6'h09);
		wr(8'h57, 8'h05);
		chk({ext, tpu, tpd, tres, pc, nc}, 6'h05);
		rd(8'h57, 8'h05);
		for (i = 0; i < 8; i++) begin
			wr(8'h56, i[7:0]);
			chk({std, sres}, {i < 6 ? 6'h01 << i : 6'h00, i > 5});
		end
		for (i = 0; i < 4; i++) begin
			wr(8'h65, {3'h0, i[1:0], 3'h0});
			chk({sup, ures}, {i < 3 ? 3'h1 << i : 3'h0, i == 3});
		end
		rd(8'h65, 8'h18);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		#1;
		rst_chk();
		wr(8'hFF, 8'h02);
		rd(8'h64, 8'h00);
		rd(8'h57, 8'h00);
		conclude();
	end
endmodule // cocr_regs_tb_top
